// *** cbs_regs.sv ***
// Functional notes
// - status bit 24 reads one while the auxiliary add-on board is attached, zero otherwise, and is read-only.
// - status bits 25 to 29 read the present levels of general inputs 0 to 4.
// - status bits 31 to 30 read the present position of the board switch.
// - control bits 0 to 5 enable the control table, overstep, hardware, trigger, serial port and quad sources.
// - with control bit 6 clear every frame end raises its interrupt, with it set only during single or continuous acquire.
// - read-only control bit 7 shows that the board is emitting an interrupt.
// - control bit 8 is a master enable; cleared, no interrupt reaches the host.
// - control bits 10 to 16 are stored and driven onto general outputs 0 to 6.
// - control bit 17 set holds the serial port reset asserted.
// - read-only control bit 18 is a sticky overstep flag, set on any overstep until cleared.
// - control bit 19 set holds the sticky overstep flag cleared.
`timescale 1ns/1ps
`default_nettype none

module cbs_regs (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [cbs_pkg::CBS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [cbs_pkg::CBS_ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic aux_board_present,
	input wire logic [4:0] general_input,
	input wire logic [1:0] board_switch_state,
	input wire cbs_pkg::cbs_events_s events,
	input wire logic [1:0] acquire_state,
	output logic [6:0] general_output,
	output logic serial_port_reset,
	output logic host_irq
);
	import cbs_pkg::*;

	logic wr_en;
	logic [CBS_ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic [31:0] rd_data;
	logic rd_ok;

	logic [7:0] pins_sync;
	logic aux_sync;
	logic [CBS_ST_GPIN_W-1:0] gpin_sync;
	logic [CBS_ST_SW_W-1:0] sw_sync;

	logic [31:0] ctl_r;
	logic [31:0] ctl_nxt;
	logic sticky_overstep_flag_r;
	logic [CBS_IRQ_W-1:0] irq_stat_r;
	logic [CBS_IRQ_W-1:0] irq_stat_nxt;
	logic [CBS_IRQ_W-1:0] irq_mask_r;
	logic [CBS_IRQ_W-1:0] irq_mask_nxt;
	logic irq_r;
	logic irq_nxt;

	// bus slave handles handshakes; this module only decodes and stores
	cbs_axil_slave u_bus (
		.clk_sys(clk_sys),
		.reset(reset),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rready(s_axi_rready),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	// board pins are asynchronous to clk_sys
	cbs_sync #(
		.WIDTH(8)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.async_in({board_switch_state, general_input, aux_board_present}),
		.sync_out(pins_sync)
	);

	assign aux_sync = pins_sync[0];
	assign gpin_sync = pins_sync[5:1];
	assign sw_sync = pins_sync[7:6];

	// write decode; low two address bits are ignored
	logic wr_status;
	logic wr_control;
	logic wr_irq_stat;
	logic wr_irq_mask;
	assign wr_status = wr_en && (wr_addr[CBS_ADDR_W-1:2] == CBS_ADDR_STATUS[CBS_ADDR_W-1:2]);
	assign wr_control = wr_en && (wr_addr[CBS_ADDR_W-1:2] == CBS_ADDR_CONTROL[CBS_ADDR_W-1:2]);
	assign wr_irq_stat = wr_en && (wr_addr[CBS_ADDR_W-1:2] == CBS_ADDR_IRQ_STATUS[CBS_ADDR_W-1:2]);
	assign wr_irq_mask = wr_en && (wr_addr[CBS_ADDR_W-1:2] == CBS_ADDR_IRQ_MASK[CBS_ADDR_W-1:2]);
	// the status word is accepted with OKAY but stores nothing
	assign wr_ok = wr_status | wr_control | wr_irq_stat | wr_irq_mask;

	// byte-lane expansion of the write strobes
	logic [31:0] wr_bits;
	assign wr_bits = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

	// only the storable control bits take write data; read-only bits keep zero here
	assign ctl_nxt = wr_control ? ((ctl_r & ~(wr_bits & CBS_CT_WR_MASK)) | (wr_data & wr_bits & CBS_CT_WR_MASK)) : ctl_r;

	// frame end only counts while acquiring when the gate bit is set
	logic acquiring;
	logic frame_end_hit;
	assign acquiring = (acquire_state == CBS_AQ_SINGLE_FRAME_ACQUIRE) || (acquire_state == CBS_AQ_CONTINUOUS_ACQUIRE);
	assign frame_end_hit = events.frame_end && (!ctl_r[CBS_CT_FRAME_GATE_BIT] || acquiring);

	// incoming event vector, frame end replaced by its gated form
	logic [CBS_IRQ_W-1:0] ev_set;
	assign ev_set = {frame_end_hit, events[CBS_IRQ_W-2:0]};

	// write-one-to-clear; a new event in the same cycle wins over the clear
	logic [CBS_IRQ_W-1:0] stat_clr;
	assign stat_clr = wr_irq_stat ? (wr_data[CBS_IRQ_W-1:0] & wr_bits[CBS_IRQ_W-1:0]) : '0;
	assign irq_stat_nxt = (irq_stat_r & ~stat_clr) | ev_set;

	assign irq_mask_nxt = wr_irq_mask ? ((irq_mask_r & ~wr_bits[CBS_IRQ_W-1:0]) | (wr_data[CBS_IRQ_W-1:0] & wr_bits[CBS_IRQ_W-1:0])) : irq_mask_r;

	// per-source enables: six from the control word, frame end governed by its gate and the mask
	logic [CBS_IRQ_W-1:0] src_en;
	assign src_en = {1'b1, ctl_r[CBS_CT_ENABLE_LSB +: CBS_CT_ENABLE_W]};

	// host interrupt needs a pending, enabled, unmasked source and the global enable
	assign irq_nxt = ctl_r[CBS_CT_GLOBAL_EN_BIT] && |(irq_stat_r & src_en & irq_mask_r);

	// control word storage; outputs drive straight from these bits
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctl_r <= CBS_CT_RESET;
		end else begin
			ctl_r <= ctl_nxt;
		end
	end

	// sticky overstep flag; the hold-clear bit overrides a simultaneous overstep
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sticky_overstep_flag_r <= 1'b0;
		end else if (ctl_r[CBS_CT_OVS_CLR_BIT]) begin
			sticky_overstep_flag_r <= 1'b0;
		end else if (events.overstep) begin
			sticky_overstep_flag_r <= 1'b1;
		end
	end

	// interrupt status, mask and the registered request line
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irq_stat_r <= CBS_IRQ_STAT_RESET;
			irq_mask_r <= CBS_IRQ_MASK_RESET;
			irq_r <= 1'b0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// read images of the two board words
	logic [31:0] status_word;
	logic [31:0] control_word;
	always_comb begin
		status_word = '0;
		status_word[CBS_ST_AUX_BIT] = aux_sync;
		status_word[CBS_ST_GPIN_LSB +: CBS_ST_GPIN_W] = gpin_sync;
		status_word[CBS_ST_SW_LSB +: CBS_ST_SW_W] = sw_sync;
	end

	always_comb begin
		control_word = ctl_r;
		control_word[CBS_CT_IRQ_ANY_BIT] = irq_r;
		control_word[CBS_CT_OVS_BIT] = sticky_overstep_flag_r;
	end

	// read decode; all four words are mapped, so every read answers OKAY
	logic [CBS_ADDR_W-3:0] rd_word;
	assign rd_word = s_axi_araddr[CBS_ADDR_W-1:2];
	assign rd_ok = 1'b1;
	always_comb begin
		case (rd_word)
			CBS_ADDR_STATUS[CBS_ADDR_W-1:2]: rd_data = status_word;
			CBS_ADDR_CONTROL[CBS_ADDR_W-1:2]: rd_data = control_word;
			CBS_ADDR_IRQ_STATUS[CBS_ADDR_W-1:2]: rd_data = {25'h0, irq_stat_r};
			CBS_ADDR_IRQ_MASK[CBS_ADDR_W-1:2]: rd_data = {25'h0, irq_mask_r};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	assign general_output = ctl_r[CBS_CT_GPOUT_LSB +: CBS_CT_GPOUT_W];
	assign serial_port_reset = ctl_r[CBS_CT_UART_RST_BIT];
	assign host_irq = irq_r;

endmodule

`default_nettype wire

// *** cbs_pkg.sv ***
package cbs_pkg;

	// register byte addresses on the bus
	localparam logic [3:0] CBS_ADDR_STATUS = 4'h0;
	localparam logic [3:0] CBS_ADDR_CONTROL = 4'h4;
	localparam logic [3:0] CBS_ADDR_IRQ_STATUS = 4'h8;
	localparam logic [3:0] CBS_ADDR_IRQ_MASK = 4'hC;
	localparam int CBS_ADDR_W = 4;

	// board status word field positions
	localparam int CBS_ST_AUX_BIT = 24;
	localparam int CBS_ST_GPIN_LSB = 25;
	localparam int CBS_ST_GPIN_W = 5;
	localparam int CBS_ST_SW_LSB = 30;
	localparam int CBS_ST_SW_W = 2;

	// interrupt and io control word field positions
	localparam int CBS_CT_ENABLE_LSB = 0;
	localparam int CBS_CT_ENABLE_W = 6;
	localparam int CBS_CT_FRAME_GATE_BIT = 6;
	localparam int CBS_CT_IRQ_ANY_BIT = 7;
	localparam int CBS_CT_GLOBAL_EN_BIT = 8;
	localparam int CBS_CT_GPOUT_LSB = 10;
	localparam int CBS_CT_GPOUT_W = 7;
	localparam int CBS_CT_UART_RST_BIT = 17;
	localparam int CBS_CT_OVS_BIT = 18;
	localparam int CBS_CT_OVS_CLR_BIT = 19;

	// bits of the control word that software may store
	localparam logic [31:0] CBS_CT_WR_MASK = 32'h000B_FD7F;
	localparam logic [31:0] CBS_CT_RESET = 32'h0000_0000;

	// interrupt sources: status and mask registers share this layout
	localparam int CBS_IRQ_W = 7;
	localparam int CBS_IRQ_FRAME_END_BIT = 6;
	localparam logic [6:0] CBS_IRQ_MASK_RESET = 7'h7F;
	localparam logic [6:0] CBS_IRQ_STAT_RESET = 7'h00;

	// acquisition state codes
	localparam logic [1:0] CBS_AQ_SINGLE_FRAME_ACQUIRE = 2'h2;
	localparam logic [1:0] CBS_AQ_CONTINUOUS_ACQUIRE = 2'h3;

	// bus responses
	localparam logic [1:0] CBS_RESP_OKAY = 2'h0;
	localparam logic [1:0] CBS_RESP_SLVERR = 2'h2;

	// one-cycle event pulses from the acquisition logic, packed msb first
	typedef struct packed {
		logic frame_end;
		logic quad_command;
		logic serial_port;
		logic trigger;
		logic hardware;
		logic overstep;
		logic control_table;
	} cbs_events_s;

endpackage

// *** cbs_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module cbs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;

	// two stages against metastability; only the second stage leaves this module
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stage1_r <= '0;
			stage2_r <= '0;
		end else begin
			stage1_r <= async_in;
			stage2_r <= stage1_r;
		end
	end

	assign sync_out = stage2_r;

endmodule

`default_nettype wire

// *** cbs_axil_slave.sv ***
`timescale 1ns/1ps
`default_nettype none

module cbs_axil_slave (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [cbs_pkg::CBS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic s_axi_rready,
	output logic s_axi_rvalid,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic wr_en,
	output logic [cbs_pkg::CBS_ADDR_W-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);
	import cbs_pkg::*;

	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [CBS_ADDR_W-1:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;

	// both halves held and no response pending: commit the write this cycle
	assign wr_en = ~awready_r & ~wready_r & ~bvalid_r;
	assign wr_addr = waddr_r;
	assign wr_data = wdata_r;
	assign wr_strb = wstrb_r;

	// write channels; address and data may arrive in either order
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			bvalid_r <= 1'b0;
			bresp_r <= CBS_RESP_OKAY;
			waddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else begin
			if (s_axi_awvalid && awready_r) begin
				waddr_r <= s_axi_awaddr;
				awready_r <= 1'b0;
			end
			if (s_axi_wvalid && wready_r) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				wready_r <= 1'b0;
			end
			if (wr_en) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? CBS_RESP_OKAY : CBS_RESP_SLVERR;
			end
			if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// read channel; data is captured at the address handshake
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= CBS_RESP_OKAY;
		end else if (s_axi_arvalid && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b1;
			rdata_r <= rd_data;
			rresp_r <= rd_ok ? CBS_RESP_OKAY : CBS_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

endmodule

`default_nettype wire

// *** cbs_regs_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module cbs_regs_props (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [cbs_pkg::CBS_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire cbs_pkg::cbs_events_s events,
	input wire logic [6:0] general_output,
	input wire logic serial_port_reset,
	input wire logic host_irq
);
	import cbs_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic [CBS_ADDR_W-1:0] ra_r;
	logic [2:0] age_r;
	wire w_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	wire rd_ct = s_axi_rvalid && ra_r == CBS_ADDR_CONTROL;
	// keep the read address so read data can be judged by register
	always_ff @(posedge clk_sys) begin
		if (ar_hs) ra_r <= s_axi_araddr;
	end
	// cycles since the last cause an interrupt could have, saturating
	always_ff @(posedge clk_sys) begin
		if (reset || |events || w_hs) age_r <= 3'h0;
		else if (age_r != 3'h7) age_r <= age_r + 3'h1;
	end
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_time; w_hs |-> ##[1:3] s_axi_bvalid; endproperty
	a_b_time: assert property (p_b_time) else $error("write response late");
	property p_r_time; ar_hs |-> ##[1:2] s_axi_rvalid; endproperty
	a_r_time: assert property (p_r_time) else $error("read data late");
	property p_b_okay; s_axi_bvalid |-> s_axi_bresp == CBS_RESP_OKAY; endproperty
	a_b_okay: assert property (p_b_okay) else $error("write refused");
	property p_gpout; !$stable(general_output) |-> $past(w_hs) || $past(w_hs, 2); endproperty
	a_gpout: assert property (p_gpout) else $error("outputs moved unwritten");
	property p_uart; !$stable(serial_port_reset) |-> $past(w_hs) || $past(w_hs, 2); endproperty
	a_uart: assert property (p_uart) else $error("serial reset moved unwritten");
	property p_glob; rd_ct && !s_axi_rdata[CBS_CT_GLOBAL_EN_BIT] |-> !s_axi_rdata[CBS_CT_IRQ_ANY_BIT]; endproperty
	a_glob: assert property (p_glob) else $error("irq with global enable off");
	property p_ovs; rd_ct && s_axi_rdata[CBS_CT_OVS_CLR_BIT] |-> !s_axi_rdata[CBS_CT_OVS_BIT]; endproperty
	a_ovs: assert property (p_ovs) else $error("overstep flag not held clear");
	property p_irq_cause; $rose(host_irq) |-> age_r <= 3'h4; endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
	c_wr: cover property (w_hs);
	c_irq: cover property ($rose(host_irq));
	c_ovs: cover property (rd_ct && s_axi_rdata[CBS_CT_OVS_BIT]);
endmodule
`default_nettype wire

// *** cbs_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, e, g) n_checks++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end
module cbs_regs_tb;
	import cbs_pkg::*;
	logic clk_sys = 0, reset = 1;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = '0, exp;
	logic aux_board_present = 0;
	logic [4:0] general_input = '0;
	logic [1:0] board_switch_state = '0, acquire_state = '0;
	cbs_events_s events = '0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_port_reset, host_irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [6:0] general_output;
	int n_errors = 0, n_checks = 0, seed = 32'hD215, cyc = 0;
	cbs_regs dut(.*);
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// a hang is cut short; the run needs under a thousand cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic aw_done, w_done;
		aw_done = 0;
		w_done = 0;
		@(posedge clk_sys);
		s_axi_awvalid <= 1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1;
		s_axi_wdata <= d;
		while (!(aw_done && w_done)) begin
			@(posedge clk_sys);
			aw_done |= s_axi_awready;
			w_done |= s_axi_wready;
			if (aw_done) s_axi_awvalid <= 0;
			if (w_done) s_axi_wvalid <= 0;
		end
		s_axi_bready <= 1;
		do @(posedge clk_sys); while (!s_axi_bvalid);
		s_axi_bready <= 0;
		`chk("bresp", CBS_RESP_OKAY, s_axi_bresp)
	endtask
	// read one word and compare it
	task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		logic [1:0] rr;
		@(posedge clk_sys);
		s_axi_arvalid <= 1;
		s_axi_araddr <= a;
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		s_axi_rready <= 1;
		do @(posedge clk_sys); while (!s_axi_rvalid);
		d = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
		`chk(nm, e, d)
		`chk("rresp", CBS_RESP_OKAY, rr)
	endtask
	// one-cycle event, then time for status and irq to settle
	task automatic pulse(input int i);
		@(posedge clk_sys);
		events <= 7'(1 << i);
		@(posedge clk_sys);
		events <= '0;
		repeat (4) @(posedge clk_sys);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		reset <= 0;
		rc(CBS_ADDR_CONTROL, CBS_CT_RESET, "ctl rst");
		rc(CBS_ADDR_IRQ_MASK, 32'(CBS_IRQ_MASK_RESET), "mask rst");
		$display("test reset done");
		// random pin levels; writes must bounce off the status word
		for (int k = 0; k < 6; k++) begin
			@(posedge clk_sys);
			aux_board_present <= $random(seed);
			general_input <= $random(seed);
			board_switch_state <= $random(seed);
			repeat (4) @(posedge clk_sys);
			exp = {board_switch_state, general_input, aux_board_present, 24'h0};
			wr(CBS_ADDR_STATUS, ~exp);
			rc(CBS_ADDR_STATUS, exp, "status");
		end
		$display("test status done");
		// all-ones first, then random control words
		for (int k = 0; k < 12; k++) begin
			exp = k == 0 ? '1 : $random(seed);
			wr(CBS_ADDR_CONTROL, exp);
			exp &= CBS_CT_WR_MASK;
			rc(CBS_ADDR_CONTROL, exp, "ctl");
			`chk("gpout", exp[16:10], general_output)
			`chk("uart rst", exp[17], serial_port_reset)
		end
		$display("test control done");
		wr(CBS_ADDR_CONTROL, 32'h0);
		pulse(1);
		rc(CBS_ADDR_CONTROL, 32'h0004_0000, "ovs set");
		wr(CBS_ADDR_CONTROL, 32'h0);
		rc(CBS_ADDR_CONTROL, 32'h0004_0000, "ovs sticky");
		wr(CBS_ADDR_CONTROL, 32'h0008_0000);
		pulse(1);
		rc(CBS_ADDR_CONTROL, 32'h0008_0000, "ovs held");
		wr(CBS_ADDR_CONTROL, 32'h0004_0000);
		rc(CBS_ADDR_CONTROL, 32'h0, "ovs ro");
		$display("test overstep done");
		// each source against its own enable and the global enable
		for (int i = 0; i < 6; i++) begin
			for (int k = 0; k < 4; k++) begin
				wr(CBS_ADDR_IRQ_STATUS, 32'h7F);
				exp = 32'(k[0]) << i | 32'(k[1]) << 8 | 32'h0008_0000;
				wr(CBS_ADDR_CONTROL, exp);
				pulse(i);
				`chk("irq", 1'(k == 3), host_irq)
				rc(CBS_ADDR_CONTROL, exp | 32'(k == 3) << 7, "irq any");
			end
		end
		wr(CBS_ADDR_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clk_sys);
		`chk("masked", 1'h0, host_irq)
		wr(CBS_ADDR_IRQ_MASK, 32'h7F);
		repeat (2) @(posedge clk_sys);
		`chk("unmasked", 1'h1, host_irq)
		$display("test sources done");
		// frame end gated by acquisition state
		for (int k = 0; k < 8; k++) begin
			wr(CBS_ADDR_IRQ_STATUS, 32'h7F);
			wr(CBS_ADDR_CONTROL, 32'(k[2]) << 6 | 32'h100);
			acquire_state <= k[1:0];
			pulse(6);
			`chk("frame irq", 1'(!k[2] || k[1]), host_irq)
		end
		$display("test frame end done");
		end_of_test();
	end
endmodule
bind cbs_regs cbs_regs_props u_props(.*);
`default_nettype wire
